// File: hw/msa_defs.svh
`ifndef MSA_DEFS_SVH
`define MSA_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define MSA_LOW_PAIR_OFS   8'h00
`define MSA_MID_PAIR_OFS   8'h10
`define MSA_HIGH_PAIR_OFS  8'h20

// Alias offsets added to a register base
`define MSA_ALIAS_PLAIN    8'h00
`define MSA_ALIAS_SET      8'h04
`define MSA_ALIAS_CLEAR    8'h08
`define MSA_ALIAS_TOGGLE   8'h0C

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
`define MSA_ADDR_W         8
`define MSA_IDX_HI         5
`define MSA_IDX_LO         4
`define MSA_OP_HI          3
`define MSA_OP_LO          2
`define MSA_TOP_HI         7
`define MSA_TOP_LO         6
`define MSA_IDX_LOW        2'h0
`define MSA_IDX_MID        2'h1
`define MSA_IDX_HIGH       2'h2
`define MSA_IDX_COUNT      3

// ----------------------------------------------------------------
// Octet fields inside a pair register
// ----------------------------------------------------------------
`define MSA_OCT_EARLY_HI   7
`define MSA_OCT_EARLY_LO   0
`define MSA_OCT_LATE_HI    15
`define MSA_OCT_LATE_LO    8
`define MSA_PAIR_W         16
`define MSA_PAIR_RST       16'h0000

// ----------------------------------------------------------------
// Byte strobes and responses
// ----------------------------------------------------------------
`define MSA_STRB_WORD      4'hF
`define MSA_STRB_LOW_HALF  4'h3
`define MSA_STRB_HIGH_HALF 4'hC
`define MSA_RESP_OKAY      2'h0
`define MSA_RESP_SLVERR    2'h2

`endif

// File: hw/msa_pkg.sv
package msa_pkg;

  // Write alias selected by address bits 3:2
  typedef enum logic [1:0] {
    OP_PLAIN            = 2'h0,
    OP_BIT_SET_ALIAS    = 2'h1,
    OP_BIT_CLEAR_ALIAS  = 2'h2,
    OP_BIT_TOGGLE_ALIAS = 2'h3
  } msa_op_t;

  // Start-up sequencer, one-hot
  typedef enum logic [3:0] {
    ST_SYNC_A = 4'b0001,
    ST_SYNC_B = 4'b0010,
    ST_LOAD   = 4'b0100,
    ST_RUN    = 4'b1000
  } msa_state_t;

endpackage

// File: hw/msa_station_addr.sv
`timescale 1ns/1ps
`include "msa_defs.svh"
// Overview of operation
// R1: High pair low byte holds first sent octet, the address MSB.
// R2: High pair bits 15:8 hold the second sent octet.
// R3: Mid pair low byte holds the third sent octet.
// R4: Mid pair bits 15:8 hold the fourth sent octet.
// R5: Low pair low byte holds the fifth sent octet.
// R6: Low pair bits 15:8 hold the sixth, last sent octet.
// R7: Halfword and word writes work, plainly and through set, clear, toggle aliases.
// R8: Byte-sized writes are ignored; stored octets stay unchanged.
// R9: After reset all three registers load the factory station address.
// R10: Upper halves of low and mid pairs always read zero.
// R11: Software writes zero to high pair upper half and ignores its read.
// R12: Octets are read/write; written values hold until next reset.
module msa_station_addr (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   clkEn,
  input  wire logic [47:0]            factoryAddr,
  output logic      [47:0]            stationAddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`MSA_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic      [1:0]             s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [`MSA_ADDR_W-1:0] s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic      [31:0]            s_axi_rdata,
  output logic      [1:0]             s_axi_rresp
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic addrMapped(input logic [`MSA_ADDR_W-1:0] a);
    return (a[`MSA_TOP_HI:`MSA_TOP_LO] == 2'h0) &&
           (a[`MSA_IDX_HI:`MSA_IDX_LO] != 2'h3) && (a[1:0] == 2'h0);
  endfunction

  // Only halfword and word strobe patterns count
  function automatic logic strbLegal(input logic [3:0] s);
    return (s == `MSA_STRB_WORD) || (s == `MSA_STRB_LOW_HALF) ||
           (s == `MSA_STRB_HIGH_HALF);
  endfunction

  function automatic logic [15:0] swapOctets(input logic [15:0] v);
    return {v[`MSA_OCT_EARLY_HI:`MSA_OCT_EARLY_LO], v[`MSA_OCT_LATE_HI:`MSA_OCT_LATE_LO]};
  endfunction

  function automatic logic [15:0] applyOp(input msa_pkg::msa_op_t op,
                                          input logic [15:0] cur,
                                          input logic [15:0] val);
    logic [15:0] res;
    res = cur;
    unique case (op)
      msa_pkg::OP_PLAIN:            res = val;
      msa_pkg::OP_BIT_SET_ALIAS:    res = cur | val;
      msa_pkg::OP_BIT_CLEAR_ALIAS:  res = cur & ~val;
      msa_pkg::OP_BIT_TOGGLE_ALIAS: res = cur ^ val;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Factory address synchroniser and start-up load
  // ----------------------------------------------------------------
  logic [47:0]          factSync1Reg;
  logic [47:0]          factSync2Reg;
  msa_pkg::msa_state_t  stateReg;
  msa_pkg::msa_state_t  stateNext;
  logic [15:0]          pairReg [`MSA_IDX_COUNT];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      factSync1Reg <= 48'h0;
      factSync2Reg <= 48'h0;
    end else if (clkEn) begin
      factSync1Reg <= factoryAddr;
      factSync2Reg <= factSync1Reg;
    end
  end

  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      msa_pkg::ST_SYNC_A: stateNext = msa_pkg::ST_SYNC_B;
      msa_pkg::ST_SYNC_B: stateNext = msa_pkg::ST_LOAD;
      msa_pkg::ST_LOAD:   stateNext = msa_pkg::ST_RUN;
      msa_pkg::ST_RUN:    stateNext = msa_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= msa_pkg::ST_SYNC_A;
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  wire running = (stateReg == msa_pkg::ST_RUN);
  wire loadNow = (stateReg == msa_pkg::ST_LOAD) && clkEn;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  logic                   awHeldReg;
  logic                   wHeldReg;
  logic [`MSA_ADDR_W-1:0] awAddrReg;
  logic [31:0]            wDataReg;
  logic [3:0]             wStrbReg;

  assign s_axi_awready = clkEn && running && !awHeldReg && !s_axi_bvalid;
  assign s_axi_wready  = clkEn && running && !wHeldReg && !s_axi_bvalid;

  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire  = s_axi_wvalid && s_axi_wready;
  wire wrGo   = clkEn && awHeldReg && wHeldReg && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      awHeldReg <= 1'b0;
      wHeldReg  <= 1'b0;
      awAddrReg <= '0;
      wDataReg  <= 32'h0;
      wStrbReg  <= 4'h0;
    end else if (clkEn) begin
      if (awFire) begin
        awHeldReg <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end else if (wrGo) begin
        awHeldReg <= 1'b0;
      end
      if (wFire) begin
        wHeldReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end else if (wrGo) begin
        wHeldReg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write decode and pair storage
  // ----------------------------------------------------------------
  wire [1:0]              wrIdx    = awAddrReg[`MSA_IDX_HI:`MSA_IDX_LO];
  wire msa_pkg::msa_op_t  wrOp     = msa_pkg::msa_op_t'(awAddrReg[`MSA_OP_HI:`MSA_OP_LO]);
  wire                    wrMapped = addrMapped(awAddrReg);
  // Upper-half-only writes touch nothing stored
  wire                    wrStore  = wrGo && wrMapped && strbLegal(wStrbReg) // R7 R8
                                     && wStrbReg[0]; // R11
  wire [15:0]             curPair  = wrMapped ? pairReg[wrIdx] : `MSA_PAIR_RST;
  wire [15:0]             newPair  = applyOp(wrOp, curPair, wDataReg[15:0]); // R7

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `MSA_IDX_COUNT; i++) begin
        pairReg[i] <= `MSA_PAIR_RST;
      end
    end else if (loadNow) begin
      for (int i = 0; i < `MSA_IDX_COUNT; i++) begin
        pairReg[i] <= swapOctets(factSync2Reg[16*i +: 16]); // R9
      end
    end else if (clkEn && wrStore) begin
      pairReg[wrIdx] <= newPair; // R12
    end
  end

  // First transmitted octet is the most significant of the address
  assign stationAddr = {swapOctets(pairReg[`MSA_IDX_HIGH]), // R1 R2
                        swapOctets(pairReg[`MSA_IDX_MID]),  // R3 R4
                        swapOctets(pairReg[`MSA_IDX_LOW])}; // R5 R6

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MSA_RESP_OKAY;
    end else if (clkEn) begin
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `MSA_RESP_OKAY : `MSA_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign s_axi_arready = clkEn && running && !s_axi_rvalid;

  wire        arFire   = s_axi_arvalid && s_axi_arready;
  wire [1:0]  rdIdx    = s_axi_araddr[`MSA_IDX_HI:`MSA_IDX_LO];
  wire        rdMapped = addrMapped(s_axi_araddr);
  wire        rdPlain  = (s_axi_araddr[`MSA_OP_HI:`MSA_OP_LO] == msa_pkg::OP_PLAIN);
  // Upper halves read zero, aliases read zero
  wire [31:0] rdWord   = (rdMapped && rdPlain) ? {16'h0, pairReg[rdIdx]} // R10 R11
                                               : 32'h0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `MSA_RESP_OKAY;
    end else if (clkEn) begin
      if (arFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord;
        s_axi_rresp  <= rdMapped ? `MSA_RESP_OKAY : `MSA_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  wire rdHigh = arFire && !wrGo &&
                (s_axi_araddr == (`MSA_HIGH_PAIR_OFS + `MSA_ALIAS_PLAIN));
  wire rdMid  = arFire && !wrGo &&
                (s_axi_araddr == (`MSA_MID_PAIR_OFS + `MSA_ALIAS_PLAIN));
  wire rdLow  = arFire && !wrGo &&
                (s_axi_araddr == (`MSA_LOW_PAIR_OFS + `MSA_ALIAS_PLAIN));

  high_pair_order_a: assert property ( // R1 R2
    rdHigh |=> s_axi_rvalid && s_axi_rdata[7:0] == stationAddr[47:40] &&
               s_axi_rdata[15:8] == stationAddr[39:32])
    else $error("high pair octet order wrong");

  mid_pair_order_a: assert property ( // R3 R4
    rdMid |=> s_axi_rvalid && s_axi_rdata[7:0] == stationAddr[31:24] &&
              s_axi_rdata[15:8] == stationAddr[23:16])
    else $error("mid pair octet order wrong");

  low_pair_order_a: assert property ( // R5 R6
    rdLow |=> s_axi_rvalid && s_axi_rdata[7:0] == stationAddr[15:8] &&
              s_axi_rdata[15:8] == stationAddr[7:0])
    else $error("low pair octet order wrong");

  halfword_write_a: assert property ( // R7 R12
    wrGo && wrMapped && wrOp == msa_pkg::OP_PLAIN && wStrbReg == `MSA_STRB_LOW_HALF
    |=> pairReg[wrIdx] == $past(wDataReg[15:0]) && s_axi_bvalid)
    else $error("halfword write not stored");

  clear_alias_a: assert property ( // R7
    wrGo && wrMapped && wrOp == msa_pkg::OP_BIT_CLEAR_ALIAS && wStrbReg == `MSA_STRB_WORD
    |=> pairReg[wrIdx] == ($past(curPair) & ~$past(wDataReg[15:0])))
    else $error("clear alias result wrong");

  word_write_a: assert property ( // R7 R12
    wrGo && wrMapped && wrOp == msa_pkg::OP_PLAIN && wStrbReg == `MSA_STRB_WORD
    |=> pairReg[wrIdx] == $past(wDataReg[15:0]))
    else $error("word write not stored");

  set_alias_a: assert property ( // R7
    wrGo && wrMapped && wrOp == msa_pkg::OP_BIT_SET_ALIAS && wStrbReg == `MSA_STRB_WORD
    |=> pairReg[wrIdx] == ($past(curPair) | $past(wDataReg[15:0])))
    else $error("set alias result wrong");

  toggle_alias_a: assert property ( // R7
    wrGo && wrMapped && wrOp == msa_pkg::OP_BIT_TOGGLE_ALIAS && wStrbReg == `MSA_STRB_WORD
    |=> pairReg[wrIdx] == ($past(curPair) ^ $past(wDataReg[15:0])))
    else $error("toggle alias result wrong");

  enable_freeze_a: assert property (
    !clkEn |=> $stable(stationAddr) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
    else $error("state moved while disabled");

  byte_ignored_a: assert property ( // R8
    wrGo && !strbLegal(wStrbReg) |=> $stable(stationAddr) && s_axi_bvalid)
    else $error("byte write changed address");

  upper_zero_a: assert property ( // R10
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper half not zero");

  factory_load_a: assert property ( // R9
    $rose(running) |-> stationAddr == $past(factSync2Reg))
    else $error("factory address not loaded");

  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  start_delay_a: assert property (
    $rose(arst_n) |-> !running [*3])
    else $error("bus opened before load");

endmodule // msa_station_addr

// File: verification/msa_station_addr_tb.sv
`timescale 1ns/1ps
`include "msa_defs.svh"
module msa_station_addr_tb;
  logic        clk_sys;
  logic        arst_n;
  logic        clkEn;
  logic [47:0] factoryAddr;
  logic [47:0] stationAddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          nErrors;
  int          totalChecks;
  localparam logic [7:0]  AL_OFS[4] = '{`MSA_ALIAS_PLAIN, `MSA_ALIAS_SET,
                                        `MSA_ALIAS_CLEAR, `MSA_ALIAS_TOGGLE};
  localparam logic [31:0] AL_DAT[4] = '{32'hFFFF1234, 32'h000000C0, 32'h00000030, 32'h0000FF00};
  localparam logic [15:0] AL_EXP[4] = '{16'h1234, 16'h12F4, 16'h12C4, 16'hEDC4};

  msa_station_addr msa_station_addr_inst (
    .clk_sys       (clk_sys),
    .arst_n        (arst_n),
    .clkEn         (clkEn),
    .factoryAddr   (factoryAddr),
    .stationAddr   (stationAddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp)
  );

  // ----------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    #(20000 * 8);
    nErrors++;
    complete_run();
  end

  task automatic do_reset(input logic [47:0] fa);
    arst_n      <= 1'b0;
    factoryAddr <= fa;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    totalChecks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      nErrors++;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic ta, tw, got;
    logic [1:0] r;
    int n;
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 60 && !got; n++) begin
      @(negedge clk_sys);
      ta  = s_axi_awvalid && s_axi_awready;
      tw  = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      r   = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (got) s_axi_bready <= 1'b0;
    end
    chk("write response", {46'h0, er}, {46'h0, got ? r : 2'h1});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, got;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 60 && !got; n++) begin
      @(negedge clk_sys);
      ta  = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d   = s_axi_rdata;
      r   = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (got) s_axi_rready <= 1'b0;
    end
    chk("read data", {16'h0, ed}, got ? {16'h0, d} : 48'hBAD);
    chk("read response", {46'h0, er}, {46'h0, r});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset_load;
    chk("station address", 48'hA1B2C3D4E5F6, stationAddr);
    rd_chk(`MSA_LOW_PAIR_OFS, 32'h0000F6E5, `MSA_RESP_OKAY);
    rd_chk(`MSA_MID_PAIR_OFS, 32'h0000D4C3, `MSA_RESP_OKAY);
    rd_chk(`MSA_HIGH_PAIR_OFS, 32'h0000B2A1, `MSA_RESP_OKAY);
    $display("test_reset_load done");
  endtask

  task automatic test_aliases;
    int i;
    for (i = 0; i < 4; i++) begin
      axi_wr(`MSA_LOW_PAIR_OFS + AL_OFS[i], AL_DAT[i], `MSA_STRB_WORD, `MSA_RESP_OKAY);
      rd_chk(`MSA_LOW_PAIR_OFS, {16'h0, AL_EXP[i]}, `MSA_RESP_OKAY);
      chk("low octets", {32'h0, AL_EXP[i][7:0], AL_EXP[i][15:8]}, {32'h0, stationAddr[15:0]});
    end
    axi_wr(`MSA_HIGH_PAIR_OFS, 32'h00005566, `MSA_STRB_WORD, `MSA_RESP_OKAY);
    chk("high octets", 48'h6655, {32'h0, stationAddr[47:32]});
    $display("test_aliases done");
  endtask

  task automatic test_sizes;
    int i;
    axi_wr(`MSA_MID_PAIR_OFS, 32'h0000ABCD, `MSA_STRB_LOW_HALF, `MSA_RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      axi_wr(`MSA_MID_PAIR_OFS, 32'h00000000, 4'h1 << i, `MSA_RESP_OKAY);
    end
    axi_wr(`MSA_MID_PAIR_OFS, 32'hFFFF0000, `MSA_STRB_HIGH_HALF, `MSA_RESP_OKAY);
    rd_chk(`MSA_MID_PAIR_OFS, 32'h0000ABCD, `MSA_RESP_OKAY);
    chk("mid octets", 48'hCDAB, {32'h0, stationAddr[31:16]});
    axi_wr(8'h30, 32'h00001111, `MSA_STRB_WORD, `MSA_RESP_SLVERR);
    rd_chk(8'h30, 32'h00000000, `MSA_RESP_SLVERR);
    $display("test_sizes done");
  endtask

  task automatic test_clock_enable;
    @(posedge clk_sys);
    clkEn <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("frozen readies", 48'h0, {45'h0, s_axi_awready, s_axi_wready, s_axi_arready});
    chk("frozen mid octets", 48'hCDAB, {32'h0, stationAddr[31:16]});
    @(posedge clk_sys);
    clkEn <= 1'b1;
    rd_chk(`MSA_MID_PAIR_OFS, 32'h0000ABCD, `MSA_RESP_OKAY);
    $display("test_clock_enable done");
  endtask

  task automatic test_second_reset;
    do_reset(48'h0211223344FE);
    chk("station address", 48'h0211223344FE, stationAddr);
    rd_chk(`MSA_HIGH_PAIR_OFS, 32'h00001102, `MSA_RESP_OKAY);
    rd_chk(`MSA_LOW_PAIR_OFS, 32'h0000FE44, `MSA_RESP_OKAY);
    $display("test_second_reset done");
  endtask

  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    nErrors       = 0;
    totalChecks   = 0;
    arst_n        = 1'b0;
    clkEn         = 1'b1;
    factoryAddr   = 48'hA1B2C3D4E5F6;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_wvalid  = 1'b0;
    s_axi_wdata   = 32'h00000000;
    s_axi_wstrb   = 4'h0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_rready  = 1'b0;
    do_reset(48'hA1B2C3D4E5F6);
    test_reset_load();
    test_aliases();
    test_sizes();
    test_clock_enable();
    test_second_reset();
    complete_run();
  end
endmodule // msa_station_addr_tb
